/* rtl/fwc_pkg.sv */
// Operation
// RULE_01: set, clear and invert carry bit alone, other flags untouched
// RULE_02: set and clear direction bit directly
// RULE_03: string step increments indexes if direction clear, else decrements
// RULE_04: flags-to-byte copies five status bits to byte bits 7,6,4,2,0
// RULE_05: byte-to-flags loads status bits from byte bits 7,6,4,2,0
// RULE_06: word push stores only the low 16 flag bits
// RULE_07: double push stores whole word with resume and v86 bits zero
// RULE_08: word pop always updates bits 11,10,8,7,6,4,2,0 only
// RULE_09: pops load io privilege bits 13:12 only at privilege level 0
// RULE_10: pops load int-enable bit 9 only when io level >= current level
// RULE_11: double pop may also change bits 18 and 21
// RULE_12: maskable interrupt serviced only while int-enable bit is set
// RULE_13: int-enable set/clear allowed only per mode and privilege level
// RULE_14: in 64-bit mode byte transfers need feature bit 0
// RULE_15: word push and pop unchanged in 64-bit mode
// RULE_16: 64-bit mode double push stores full 64-bit word, bits cleared
// RULE_17: 64-bit mode double pop loads low 32 bits, zeroes upper half
// RULE_18: flag changes visible to the very next instruction
package fwc_pkg;

    localparam int unsigned FWC_FLAGS_W = 64;
    localparam int unsigned FWC_HALF_W  = 32;
    localparam int unsigned FWC_WORD_W  = 16;

    localparam int unsigned CARRY_POS   = 0;
    localparam int unsigned PARITY_POS  = 2;
    localparam int unsigned AUX_POS     = 4;
    localparam int unsigned ZERO_POS    = 6;
    localparam int unsigned SIGN_POS    = 7;
    localparam int unsigned INT_EN_POS  = 9;
    localparam int unsigned DIR_POS     = 10;
    localparam int unsigned IO_PRIVILEGE_LEVEL_LO     = 12;
    localparam int unsigned IO_PRIVILEGE_LEVEL_HI     = 13;
    localparam int unsigned FEATURE_POS = 0;

    localparam logic [63:0] FLAGS_RESET   = 64'h0000_0000_0000_0000;
    localparam logic [63:0] POP_WORD_MASK = 64'h0000_0000_0000_0DD5;
    localparam logic [63:0] POP_DBL_MASK  = 64'h0000_0000_0024_0000;
    localparam logic [63:0] IO_PRIVILEGE_LEVEL_MASK     = 64'h0000_0000_0000_3000;
    localparam logic [63:0] INT_EN_MASK   = 64'h0000_0000_0000_0200;
    localparam logic [63:0] PUSH_CLR_MASK = 64'h0000_0000_0003_0000;
    localparam logic [7:0]  BYTE_MASK     = 8'hD5;
    localparam logic [3:0]  BYTES_WORD    = 4'h2;
    localparam logic [3:0]  BYTES_DBL     = 4'h4;
    localparam logic [3:0]  BYTES_QUAD    = 4'h8;
    localparam logic [1:0]  CPL_TOP       = 2'h0;

    typedef enum logic [3:0] {
        OP_NOP, OP_SET_CARRY, OP_CLR_CARRY, OP_INV_CARRY,
        OP_SET_DIR, OP_CLR_DIR, OP_FLAGS_TO_BYTE, OP_BYTE_TO_FLAGS,
        OP_PUSH_WORD, OP_PUSH_DOUBLE, OP_POP_WORD, OP_POP_DOUBLE,
        OP_SET_INT, OP_CLR_INT, OP_STRING_STEP
    } fwc_op_t;

    // bits a pop may write, given privilege state
    function automatic logic [63:0] fwc_pop_mask(
        input logic [1:0] current_privilege_level,
        input logic [1:0] io_privilege_level,
        input logic       dbl
    );
        logic [63:0] m;
        m = POP_WORD_MASK;
        if (dbl) begin
            m = m | POP_DBL_MASK;
        end
        if (current_privilege_level == CPL_TOP) begin
            m = m | IO_PRIVILEGE_LEVEL_MASK;
        end
        if (io_privilege_level >= current_privilege_level) begin
            m = m | INT_EN_MASK;
        end
        return m;
    endfunction

    function automatic logic [63:0] fwc_step_amt(input logic [1:0] lg);
        return 64'h0000_0000_0000_0001 << lg;
    endfunction

endpackage

/* rtl/fwc_index_step.sv */
`timescale 1ns/1ps
module fwc_index_step
    import fwc_pkg::*;
#(
    parameter int unsigned IDX_W = 64
) (
    input  wire logic [IDX_W-1:0] idx_cur,
    input  wire logic             dir_down,
    input  wire logic [1:0]       elem_log2,
    output logic      [IDX_W-1:0] idx_next
);
    logic [63:0]      step_full;
    logic [IDX_W-1:0] step;

    always_comb begin
        step_full = fwc_step_amt(elem_log2);
        step      = step_full[IDX_W-1:0];
        // wraps at the index width, as the address counter does
        if (dir_down) begin
            idx_next = idx_cur - step; // [RULE_03]
        end else begin
            idx_next = idx_cur + step; // [RULE_03]
        end
    end
endmodule

/* rtl/fwc_pop_merge.sv */
`timescale 1ns/1ps
module fwc_pop_merge
    import fwc_pkg::*;
(
    input  wire logic [63:0] flags_cur,
    input  wire logic [63:0] popped,
    input  wire logic [1:0]  current_privilege_level,
    input  wire logic        dbl,
    input  wire logic        long_mode,
    output logic      [63:0] flags_new
);
    logic [63:0] m;
    logic [63:0] mix;

    always_comb begin
        // old io level decides the int-enable guard, not the popped one
        m   = fwc_pop_mask(current_privilege_level, flags_cur[IO_PRIVILEGE_LEVEL_HI:IO_PRIVILEGE_LEVEL_LO], // [RULE_09]
                           dbl); // [RULE_08] [RULE_10] [RULE_11]
        mix = (flags_cur & ~m) | (popped & m);
        if (dbl && long_mode) begin
            flags_new = 64'(mix[FWC_HALF_W-1:0]); // [RULE_17]
        end else begin
            flags_new = mix; // [RULE_15]
        end
    end
endmodule

/* rtl/fwc_top.sv */
`timescale 1ns/1ps
module fwc_top
    import fwc_pkg::*;
#(
    parameter int unsigned IDX_W = 64
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             instr_valid,
    input  wire fwc_op_t          instr_op,
    input  wire logic             long_mode,
    input  wire logic             prot_mode,
    input  wire logic [1:0]       current_privilege_level,
    input  wire logic [31:0]      ext_feature_ecx,
    input  wire logic [7:0]       accumulator_high_byte,
    input  wire logic [63:0]      pop_data,
    input  wire logic             idx_load,
    input  wire logic [IDX_W-1:0] src_init,
    input  wire logic [IDX_W-1:0] dst_init,
    input  wire logic [1:0]       elem_log2,
    input  wire logic             maskable_irq_input,
    output logic      [63:0]      wide_flags_word,
    output logic      [7:0]       ah_result,
    output logic                  ah_result_we,
    output logic      [63:0]      push_data,
    output logic      [3:0]       push_bytes,
    output logic                  push_we,
    output logic                  fault_undef,
    output logic                  fault_protect,
    output logic                  irq_take,
    output logic      [IDX_W-1:0] source_index_reg,
    output logic      [IDX_W-1:0] dest_index_reg
);

    typedef struct packed {
        logic [63:0]      flags;
        logic [IDX_W-1:0] src;
        logic [IDX_W-1:0] dst;
        logic [7:0]       ah;
        logic             ah_we;
        logic [63:0]      push;
        logic [3:0]       push_bytes;
        logic             push_we;
        logic             f_ud;
        logic             f_gp;
        logic             irq;
    } fwc_state_t;

    localparam fwc_state_t STATE_RESET = '{
        flags:      FLAGS_RESET,
        src:        '0,
        dst:        '0,
        ah:         '0,
        ah_we:      1'b0,
        push:       '0,
        push_bytes: '0,
        push_we:    1'b0,
        f_ud:       1'b0,
        f_gp:       1'b0,
        irq:        1'b0
    };

    fwc_state_t       st_q;
    fwc_state_t       st_d;
    logic [63:0]      pop_flags;
    logic [IDX_W-1:0] src_step;
    logic [IDX_W-1:0] dst_step;
    logic [1:0]       io_privilege_level_cur;
    logic             byte_ok;
    logic             int_ok;
    logic             do_op;
    logic             is_pop;
    logic [63:0]      push_img;
    logic [63:0]      step_full;

    assign io_privilege_level_cur = st_q.flags[IO_PRIVILEGE_LEVEL_HI:IO_PRIVILEGE_LEVEL_LO];
    assign do_op    = instr_valid;
    assign is_pop   = (instr_op == OP_POP_WORD)
                   || (instr_op == OP_POP_DOUBLE);
    assign step_full = fwc_step_amt(elem_log2);

    // outside 64-bit mode the byte transfers are always present
    assign byte_ok = !long_mode || ext_feature_ecx[FEATURE_POS]; // [RULE_14]
    // real mode has no privilege check; v86 sensitivity left to the pipe
    assign int_ok  = !prot_mode || (io_privilege_level_cur >= current_privilege_level); // [RULE_13]

    fwc_pop_merge u_pop (
        .flags_cur (st_q.flags),
        .popped    (pop_data),
        .current_privilege_level       (current_privilege_level),
        .dbl       (instr_op == OP_POP_DOUBLE),
        .long_mode (long_mode),
        .flags_new (pop_flags)
    );

    fwc_index_step #(.IDX_W(IDX_W)) u_src (
        .idx_cur   (st_q.src),
        .dir_down  (st_q.flags[DIR_POS]),
        .elem_log2 (elem_log2),
        .idx_next  (src_step)
    );

    fwc_index_step #(.IDX_W(IDX_W)) u_dst (
        .idx_cur   (st_q.dst),
        .dir_down  (st_q.flags[DIR_POS]),
        .elem_log2 (elem_log2),
        .idx_next  (dst_step)
    );

    always_comb begin
        st_d            = st_q;
        st_d.ah_we      = 1'b0;
        st_d.push_we    = 1'b0;
        st_d.f_ud       = 1'b0;
        st_d.f_gp       = 1'b0;
        push_img        = st_q.flags & ~PUSH_CLR_MASK;
        // the mask acts on the flag as it stands this cycle
        st_d.irq = maskable_irq_input && st_q.flags[INT_EN_POS]; // [RULE_12]
        if (idx_load) begin
            st_d.src = src_init;
            st_d.dst = dst_init;
        end
        if (do_op) begin
            unique case (instr_op)
                OP_NOP: begin
                end
                OP_SET_CARRY: begin
                    st_d.flags[CARRY_POS] = 1'b1; // [RULE_01]
                end
                OP_CLR_CARRY: begin
                    st_d.flags[CARRY_POS] = 1'b0; // [RULE_01]
                end
                OP_INV_CARRY: begin
                    st_d.flags[CARRY_POS] = !st_q.flags[CARRY_POS]; // [RULE_01]
                end
                OP_SET_DIR: begin
                    st_d.flags[DIR_POS] = 1'b1; // [RULE_02]
                end
                OP_CLR_DIR: begin
                    st_d.flags[DIR_POS] = 1'b0; // [RULE_02]
                end
                OP_FLAGS_TO_BYTE: begin
                    if (byte_ok) begin
                        // untouched byte bits pass through from the source
                        st_d.ah = (accumulator_high_byte & ~BYTE_MASK)
                                | (st_q.flags[7:0] & BYTE_MASK); // [RULE_04]
                        st_d.ah_we = 1'b1;
                    end else begin
                        st_d.f_ud = 1'b1; // [RULE_14]
                    end
                end
                OP_BYTE_TO_FLAGS: begin
                    if (byte_ok) begin
                        st_d.flags[7:0] = (st_q.flags[7:0] & ~BYTE_MASK)
                            | (accumulator_high_byte & BYTE_MASK); // [RULE_05]
                    end else begin
                        st_d.f_ud = 1'b1; // [RULE_14]
                    end
                end
                OP_PUSH_WORD: begin
                    st_d.push = 64'(st_q.flags[FWC_WORD_W-1:0]); // [RULE_06]
                    st_d.push_bytes = BYTES_WORD; // [RULE_15]
                    st_d.push_we    = 1'b1;
                end
                OP_PUSH_DOUBLE: begin
                    if (long_mode) begin
                        st_d.push       = push_img; // [RULE_16]
                        st_d.push_bytes = BYTES_QUAD;
                    end else begin
                        st_d.push = 64'(push_img[FWC_HALF_W-1:0]); // [RULE_07]
                        st_d.push_bytes = BYTES_DBL;
                    end
                    st_d.push_we = 1'b1;
                end
                OP_POP_WORD, OP_POP_DOUBLE: begin
                    st_d.flags = pop_flags; // [RULE_08] [RULE_11] [RULE_17]
                end
                OP_SET_INT: begin
                    if (int_ok) begin
                        st_d.flags[INT_EN_POS] = 1'b1; // [RULE_13]
                    end else begin
                        st_d.f_gp = 1'b1; // [RULE_13]
                    end
                end
                OP_CLR_INT: begin
                    if (int_ok) begin
                        st_d.flags[INT_EN_POS] = 1'b0; // [RULE_13]
                    end else begin
                        st_d.f_gp = 1'b1; // [RULE_13]
                    end
                end
                OP_STRING_STEP: begin
                    // a reload in the same cycle wins over the step
                    if (!idx_load) begin
                        st_d.src = src_step; // [RULE_03]
                        st_d.dst = dst_step; // [RULE_03]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // flags are written on the issuing edge so the next op sees them
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= STATE_RESET;
        end else if (clk_en) begin
            st_q <= st_d; // [RULE_18]
        end
    end

    assign wide_flags_word  = st_q.flags;
    assign ah_result        = st_q.ah;
    assign ah_result_we     = st_q.ah_we;
    assign push_data        = st_q.push;
    assign push_bytes       = st_q.push_bytes;
    assign push_we          = st_q.push_we;
    assign fault_undef      = st_q.f_ud;
    assign fault_protect    = st_q.f_gp;
    assign irq_take         = st_q.irq;
    assign source_index_reg = st_q.src;
    assign dest_index_reg   = st_q.dst;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    function automatic logic issue(input fwc_op_t op);
        return clk_en && instr_valid && (instr_op == op);
    endfunction

    a_carry_set_only: assert property ( // [RULE_01]
        issue(OP_SET_CARRY) |=> wide_flags_word[CARRY_POS]
            && (wide_flags_word[63:1] == $past(wide_flags_word[63:1])))
        else $error("carry set changed the wrong bits");

    a_carry_invert: assert property ( // [RULE_01]
        issue(OP_INV_CARRY) |=> wide_flags_word[CARRY_POS]
            != $past(wide_flags_word[CARRY_POS]))
        else $error("carry invert did not toggle");

    a_dir_set_clear: assert property ( // [RULE_02]
        issue(OP_SET_DIR) ##1 issue(OP_CLR_DIR)
            |-> wide_flags_word[DIR_POS] ##1
            !wide_flags_word[DIR_POS])
        else $error("direction set then clear failed");

    a_byte_copy: assert property ( // [RULE_04]
        issue(OP_FLAGS_TO_BYTE) && byte_ok |=> ah_result_we
            && ((ah_result & BYTE_MASK)
                == ($past(wide_flags_word[7:0]) & BYTE_MASK))
            && (wide_flags_word == $past(wide_flags_word)))
        else $error("flags to byte copy wrong");

    a_byte_load: assert property ( // [RULE_05]
        issue(OP_BYTE_TO_FLAGS) && byte_ok |=>
            (wide_flags_word[7:0] & BYTE_MASK)
            == ($past(accumulator_high_byte) & BYTE_MASK))
        else $error("byte to flags load wrong");

    a_push_word_low: assert property ( // [RULE_06]
        issue(OP_PUSH_WORD) |=> push_we && (push_bytes == BYTES_WORD)
            && (push_data == 64'($past(wide_flags_word[15:0]))))
        else $error("word push image wrong");

    a_push_dbl_clear: assert property ( // [RULE_07]
        issue(OP_PUSH_DOUBLE) |=> push_we
            && ((push_data & PUSH_CLR_MASK) == '0))
        else $error("double push leaked resume or v86 bit");

    a_push_quad_size: assert property ( // [RULE_16]
        issue(OP_PUSH_DOUBLE) && long_mode |=> push_bytes == BYTES_QUAD)
        else $error("long mode double push not 8 bytes");

    a_pop_word_keep: assert property ( // [RULE_08]
        issue(OP_POP_WORD) |=>
            (wide_flags_word[63:14] == $past(wide_flags_word[63:14]))
            && (wide_flags_word[5] == $past(wide_flags_word[5]))
            && (wide_flags_word[3] == $past(wide_flags_word[3])))
        else $error("word pop touched protected bits");

    a_io_privilege_level_guard: assert property ( // [RULE_09]
        clk_en && instr_valid && is_pop && (current_privilege_level != CPL_TOP) |=>
            $stable(wide_flags_word[IO_PRIVILEGE_LEVEL_HI:IO_PRIVILEGE_LEVEL_LO]))
        else $error("io level changed at low privilege");

    a_int_en_guard: assert property ( // [RULE_10]
        clk_en && instr_valid && is_pop && (io_privilege_level_cur < current_privilege_level) |=>
            $stable(wide_flags_word[INT_EN_POS]))
        else $error("int enable popped without right");

    a_pop_dbl_upper: assert property ( // [RULE_17]
        issue(OP_POP_DOUBLE) && long_mode |=>
            wide_flags_word[63:FWC_HALF_W] == '0)
        else $error("upper flags not cleared");

    a_irq_masked: assert property ( // [RULE_12]
        clk_en && maskable_irq_input && !wide_flags_word[INT_EN_POS]
            |=> !irq_take)
        else $error("masked interrupt taken");

    a_int_priv: assert property ( // [RULE_13]
        issue(OP_SET_INT) && !int_ok |=> fault_protect
            && $stable(wide_flags_word))
        else $error("int enable set without privilege");

    a_byte_feature: assert property ( // [RULE_14]
        issue(OP_FLAGS_TO_BYTE) && !byte_ok |=> fault_undef
            && !ah_result_we)
        else $error("byte transfer ran without feature");

    a_step_dir: assert property ( // [RULE_03]
        issue(OP_STRING_STEP) && !idx_load && !wide_flags_word[DIR_POS]
            |=> source_index_reg == $past(source_index_reg)
                + $past(step_full[IDX_W-1:0]))
        else $error("index did not increment");

    a_step_down: assert property ( // [RULE_03]
        issue(OP_STRING_STEP) && !idx_load && wide_flags_word[DIR_POS]
            |=> dest_index_reg == $past(dest_index_reg)
                - $past(step_full[IDX_W-1:0]))
        else $error("index did not decrement");

    a_carry_clear: assert property ( // [RULE_01]
        issue(OP_CLR_CARRY) |=> !wide_flags_word[CARRY_POS]
            && (wide_flags_word[63:1] == $past(wide_flags_word[63:1])))
        else $error("carry clear changed the wrong bits");

    a_irq_service: assert property ( // [RULE_12]
        clk_en && maskable_irq_input && wide_flags_word[INT_EN_POS]
            |=> irq_take)
        else $error("enabled interrupt not taken");

    a_push_dbl_image: assert property ( // [RULE_07]
        issue(OP_PUSH_DOUBLE) && !long_mode |=> (push_bytes == BYTES_DBL)
            && (push_data == (64'($past(wide_flags_word[FWC_HALF_W-1:0]))
                & ~PUSH_CLR_MASK)))
        else $error("double push image wrong");

    a_int_clr_priv: assert property ( // [RULE_13]
        issue(OP_CLR_INT) && !int_ok |=> fault_protect
            && $stable(wide_flags_word))
        else $error("int enable cleared without privilege");

    c_pop_full: cover property (issue(OP_POP_DOUBLE) && current_privilege_level == CPL_TOP);
    c_irq_taken: cover property (irq_take);
    c_down_step: cover property (
        issue(OP_SET_DIR) ##1 issue(OP_STRING_STEP));
    c_priv_fault: cover property (fault_protect);

endmodule

/* testbench/fwc_stack_model.sv */
`timescale 1ns/1ps
module fwc_stack_model
    import fwc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        fill_we,
    input  wire logic [63:0] fill_data,
    input  wire logic        push_we,
    input  wire logic [63:0] push_data,
    input  wire logic        pop_now,
    output logic      [63:0] pop_data
);
    logic [63:0] mem_q [0:7];
    logic [2:0]  sp_q;
    logic [63:0] junk_q;

    // empty stack shows a changing pattern so a stale value never passes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sp_q   <= 3'h0;
            junk_q <= 64'h5555_5555_5555_5555;
        end else begin
            junk_q <= ~junk_q;
            if (fill_we || push_we) begin
                mem_q[sp_q] <= fill_we ? fill_data : push_data;
                sp_q        <= sp_q + 3'h1;
            end else if (pop_now && sp_q != 3'h0) begin
                sp_q <= sp_q - 3'h1;
            end
        end
    end

    assign pop_data = (sp_q == 3'h0) ? junk_q : mem_q[sp_q - 3'h1];
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    $display("ERROR %s expected %h seen %h", nm, ex, got); \
    fail_count++; end end
module tb_top
    import fwc_pkg::*;
;
    logic        clk_sys, sys_rst, clk_en, instr_valid;
    fwc_op_t     instr_op;
    logic        long_mode, prot_mode, idx_load, maskable_irq_input;
    logic [1:0]  current_privilege_level, elem_log2;
    logic [31:0] ext_feature_ecx;
    logic [7:0]  accumulator_high_byte, ah_result;
    logic [63:0] pop_data, src_init, dst_init, push_data, fw;
    logic [63:0] fill_data, source_index_reg, dest_index_reg;
    logic        ah_result_we, push_we, fault_undef, fault_protect;
    logic        irq_take, fill_we, pop_now;
    logic [3:0]  push_bytes;
    int          fail_count, checks_done, cycles;

    assign pop_now = clk_en & instr_valid &
                     (instr_op == OP_POP_WORD || instr_op == OP_POP_DOUBLE);

    fwc_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr_op(instr_op),
        .long_mode(long_mode), .prot_mode(prot_mode), .current_privilege_level(current_privilege_level),
        .ext_feature_ecx(ext_feature_ecx),
        .accumulator_high_byte(accumulator_high_byte),
        .pop_data(pop_data), .idx_load(idx_load), .src_init(src_init),
        .dst_init(dst_init), .elem_log2(elem_log2),
        .maskable_irq_input(maskable_irq_input), .wide_flags_word(fw),
        .ah_result(ah_result), .ah_result_we(ah_result_we),
        .push_data(push_data), .push_bytes(push_bytes), .push_we(push_we),
        .fault_undef(fault_undef), .fault_protect(fault_protect),
        .irq_take(irq_take), .source_index_reg(source_index_reg),
        .dest_index_reg(dest_index_reg));

    fwc_stack_model stack (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .fill_we(fill_we), .fill_data(fill_data), .push_we(push_we),
        .push_data(push_data), .pop_now(pop_now), .pop_data(pop_data));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ceiling well above the roughly 60 cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            summarize();
        end
    end

    // valid stays high across calls so ops can run back to back
    task automatic op(input fwc_op_t o);
        instr_valid = 1'b1;
        instr_op    = o;
        @(negedge clk_sys);
    endtask

    task automatic idle();
        instr_valid = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic fill(input logic [63:0] d);
        fill_we   = 1'b1;
        fill_data = d;
        @(negedge clk_sys);
        fill_we   = 1'b0;
    endtask

    initial begin
        sys_rst = 1'b1; clk_en = 1'b1; instr_valid = 1'b0;
        instr_op = OP_NOP; long_mode = 1'b0; prot_mode = 1'b0;
        current_privilege_level = 2'h0; ext_feature_ecx = 32'h0000_0000;
        accumulator_high_byte = 8'h00; idx_load = 1'b0;
        src_init = 64'h0; dst_init = 64'h0; elem_log2 = 2'h0;
        maskable_irq_input = 1'b0; fill_we = 1'b0; fill_data = 64'h0;
        fail_count = 0; checks_done = 0; cycles = 0;
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        `CHK("flags reset", 64'h0, fw)
        @(negedge clk_sys);
        op(OP_SET_CARRY); `CHK("carry set", 64'h1, fw)
        op(OP_INV_CARRY); `CHK("carry inv", 64'h0, fw)
        op(OP_INV_CARRY); `CHK("carry inv", 64'h1, fw)
        op(OP_CLR_CARRY); `CHK("carry clr", 64'h0, fw)
        op(OP_SET_DIR); `CHK("dir pulse", 64'h400, fw)
        op(OP_CLR_DIR); `CHK("dir pair", 64'h0, fw)
        clk_en = 1'b0;
        op(OP_SET_CARRY); `CHK("frozen", 64'h0, fw)
        clk_en = 1'b1;
        idle();
        $display("test carry done");
        idx_load = 1'b1; src_init = 64'h0100; dst_init = 64'h0200;
        @(negedge clk_sys);
        idx_load = 1'b0; elem_log2 = 2'h2;
        op(OP_SET_DIR); `CHK("dir set", 64'h400, fw)
        op(OP_STRING_STEP); `CHK("src dn", 64'hFC, source_index_reg)
        `CHK("dst dn", 64'h1FC, dest_index_reg)
        op(OP_CLR_DIR); `CHK("dir clr", 64'h0, fw)
        elem_log2 = 2'h0;
        op(OP_STRING_STEP); `CHK("src up", 64'hFD, source_index_reg)
        `CHK("dst up", 64'h1FD, dest_index_reg)
        idle();
        $display("test direction done");
        accumulator_high_byte = 8'hFF;
        op(OP_BYTE_TO_FLAGS); `CHK("b2f", 64'hD5, fw)
        op(OP_CLR_CARRY);
        accumulator_high_byte = 8'h2A;
        op(OP_FLAGS_TO_BYTE); `CHK("f2b", 8'hFE, ah_result)
        `CHK("f2b we", 1'b1, ah_result_we)
        `CHK("f2b flags", 64'hD4, fw)
        idle(); `CHK("f2b we off", 1'b0, ah_result_we)
        $display("test byte transfer done");
        prot_mode = 1'b1; current_privilege_level = 2'h3;
        op(OP_SET_INT); `CHK("int refuse", 1'b1, fault_protect)
        `CHK("int kept", 64'hD4, fw)
        op(OP_CLR_INT); `CHK("clr refuse", 1'b1, fault_protect)
        prot_mode = 1'b0;
        op(OP_SET_INT); `CHK("int set", 64'h2D4, fw)
        `CHK("no refuse", 1'b0, fault_protect)
        maskable_irq_input = 1'b1;
        idle(); `CHK("irq taken", 1'b1, irq_take)
        op(OP_CLR_INT); idle(); `CHK("irq mask", 1'b0, irq_take)
        op(OP_SET_INT); idle();
        $display("test interrupt done");
        prot_mode = 1'b1;
        fill(64'hFFFF_FFFF_FFFF_FDFF);
        op(OP_POP_WORD); `CHK("pop w", 64'hFD5, fw)
        idle(); current_privilege_level = 2'h0;
        fill(64'hFFFF_FFFF_FFFF_FDFF);
        op(OP_POP_DOUBLE); `CHK("pop d", 64'h24_3DD5, fw)
        op(OP_PUSH_WORD); `CHK("push w", 64'h3DD5, push_data)
        `CHK("push w n", BYTES_WORD, push_bytes)
        `CHK("push w we", 1'b1, push_we)
        op(OP_PUSH_DOUBLE); `CHK("push d", 64'h24_3DD5, push_data)
        `CHK("push d n", BYTES_DBL, push_bytes)
        long_mode = 1'b1;
        op(OP_PUSH_DOUBLE); `CHK("push q n", BYTES_QUAD, push_bytes)
        `CHK("push q", 64'h24_3DD5, push_data)
        op(OP_PUSH_WORD); `CHK("push lw", 64'h3DD5, push_data)
        `CHK("push lw n", BYTES_WORD, push_bytes)
        idle(); `CHK("push we off", 1'b0, push_we)
        $display("test push pop done");
        fill(64'hFFFF_FFFF_0000_0000);
        op(OP_POP_DOUBLE); `CHK("pop q", 64'h0, fw)
        idle();
        fill(64'h0000_0000_0000_FFFF);
        op(OP_POP_WORD); `CHK("pop lw", 64'h3FD5, fw)
        accumulator_high_byte = 8'h00;
        op(OP_BYTE_TO_FLAGS); `CHK("undef b2f", 1'b1, fault_undef)
        `CHK("undef kept", 64'h3FD5, fw)
        op(OP_FLAGS_TO_BYTE); `CHK("undef f2b", 1'b1, fault_undef)
        `CHK("undef we", 1'b0, ah_result_we)
        ext_feature_ecx = 32'h0000_0001;
        op(OP_BYTE_TO_FLAGS); `CHK("feat b2f", 64'h3F00, fw)
        `CHK("feat ok", 1'b0, fault_undef)
        idle();
        $display("test wide mode done");
        summarize();
    end
endmodule
